// ### design/mmd_map.svh
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

`define IDX_ACCESS_CONTROL     6'h0d
`define IDX_PORT               6'h0e
`define IDX_SPEED_CAPABILITY   6'h0f
`define IDX_LINE_CONTROL       6'h10

`define SPACE_ONE              5'h01
`define SPACE_THREE            5'h03
`define SPACE_SEVEN            5'h07

`define SPEED_CAPABILITY_VALUE 16'h2000
`define PAIR_SWAP_RESET        2'h3
`define POLARITY_REV_RESET     1'h1
`define SPEED_10               2'h0
`define SPEED_100              2'h1

`endif

// ### design/mmd_pkg.sv
package mmd_pkg;

  typedef enum logic [1:0] {
    port_address   = 2'b00,
    data_hold      = 2'b01,
    data_inc_all   = 2'b10,
    data_inc_write = 2'b11
  } port_function_type;

  typedef struct packed {
    port_function_type port_function_select;
    logic [4:0]        selected_space_id;
  } access_control_type;

  typedef struct packed {
    logic [1:0] pair_swap_mode;
    logic       carrier_on_transmit;
    logic       heartbeat_test_enable;
    logic       polarity_reversal_enable;
    logic       jabber_detect_disable;
  } line_control_type;

  typedef struct packed {
    logic [1:0] speed;
    logic       full_duplex;
    logic       transmitting;
    logic       receiving;
  } link_state_type;

  typedef struct packed {
    logic carrier_sense;
    logic heartbeat_test_active;
    logic force_normal_polarity;
    logic jabber_detect_active;
  } line_action_type;

  typedef enum logic [1:0] {
    bus_idle   = 2'b00,
    bus_fetch  = 2'b01,
    bus_answer = 2'b10
  } bus_state_type;

endpackage : mmd_pkg

// ### design/space_memory.sv
`timescale 1ns/100ps
`default_nettype none

module space_memory #(
  parameter int WIDTH      = 16,
  parameter int INDEX_BITS = 7
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  read_enable,
  input  wire logic [INDEX_BITS-1:0] read_index,
  input  wire logic                  write_enable,
  input  wire logic [INDEX_BITS-1:0] write_index,
  input  wire logic [WIDTH-1:0]      write_data,
  output logic      [WIDTH-1:0]      read_data
);

  // No reset on the array: a word holds no defined value until written
  logic [WIDTH-1:0] words [2**INDEX_BITS];

  always_ff @(posedge clock) begin
    if (write_enable) begin
      words[write_index] <= write_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= '0;
    end else if (read_enable) begin
      read_data <= words[read_index];
    end
  end

endmodule : space_memory

`default_nettype wire

// ### design/mmd_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "mmd_map.svh"

module mmd_control #(
  parameter int SPACE_ADDRESS_BITS = 5
) (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic [7:0]                address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  input  wire mmd_pkg::link_state_type   link_state,
  output mmd_pkg::line_control_type      line_control_out,
  output mmd_pkg::line_action_type       line_action
);

  localparam int INDEX_BITS = SPACE_ADDRESS_BITS + 2;

  // Byte address of a register is its index times four
  function automatic logic hits(input logic [7:0] addr,
                                input logic [5:0] index);
    return addr == {index, 2'b00};
  endfunction : hits

  // Slot 3 marks a space code that holds nothing
  function automatic logic [1:0] slot_of(input logic [4:0] space);
    case (space)
      `SPACE_ONE:   return 2'd0;
      `SPACE_THREE: return 2'd1;
      `SPACE_SEVEN: return 2'd2;
      default:      return 2'd3;
    endcase
  endfunction : slot_of

  function automatic logic [15:0] merge16(input logic [15:0] old_value,
                                          input logic [15:0] new_value,
                                          input logic [1:0]  lanes);
    logic [15:0] result;
    result = old_value;
    if (lanes[0]) begin
      result[7:0] = new_value[7:0];
    end
    if (lanes[1]) begin
      result[15:8] = new_value[15:8];
    end
    return result;
  endfunction : merge16

  mmd_pkg::bus_state_type      bus_state;
  mmd_pkg::access_control_type access_control;
  mmd_pkg::line_control_type   line_control;
  logic [15:0]                 space_address [3];
  logic [15:0]                 selected_address;
  logic [1:0]                  slot;
  logic                        slot_valid;
  logic                        request;
  logic                        data_function;
  logic                        port_access;
  logic                        step_address;
  logic                        commit;
  logic [15:0]                 merged;
  logic [15:0]                 memory_data;
  logic [15:0]                 current_value;
  logic                        memory_write;
  logic [INDEX_BITS-1:0]       memory_index;
  mmd_pkg::link_state_type     link_meta;
  mmd_pkg::link_state_type     link_sync;

  assign request    = read | write;
  assign slot       = slot_of(access_control.selected_space_id);
  assign slot_valid = slot != 2'd3;
  assign port_access = hits(address, `IDX_PORT);
  assign commit     = bus_state == mmd_pkg::bus_answer;
  assign merged     = merge16(readdata[15:0], writedata[15:0],
                              byteenable[1:0]);

  // Any code other than 00 is a data function
  assign data_function = access_control.port_function_select
                         != mmd_pkg::port_address;

  // Post increment happens after the access completes
  always_comb begin
    unique case (access_control.port_function_select)
      mmd_pkg::port_address:   step_address = 1'b0;
      mmd_pkg::data_hold:      step_address = 1'b0;
      mmd_pkg::data_inc_all:   step_address = 1'b1;
      mmd_pkg::data_inc_write: step_address = write;
    endcase
  end

  always_comb begin
    unique case (slot)
      2'd0:    selected_address = space_address[0];
      2'd1:    selected_address = space_address[1];
      2'd2:    selected_address = space_address[2];
      default: selected_address = 16'h0000;
    endcase
  end

  // Low address bits only: higher stored bits alias onto the same word
  assign memory_index = {slot, selected_address[SPACE_ADDRESS_BITS-1:0]};
  assign memory_write = commit & write & port_access & data_function
                        & slot_valid;

  space_memory #(
    .WIDTH      (16),
    .INDEX_BITS (INDEX_BITS)
  ) data_store (
    .clock        (clock),
    .reset        (reset),
    .read_enable  (bus_state == mmd_pkg::bus_idle && request),
    .read_index   (memory_index),
    .write_enable (memory_write),
    .write_index  (memory_index),
    .write_data   (merged),
    .read_data    (memory_data)
  );

  // Bus sequence: idle, fetch while the memory reads, answer
  always_ff @(posedge clock) begin
    if (reset) begin
      bus_state <= mmd_pkg::bus_idle;
    end else begin
      unique case (bus_state)
        mmd_pkg::bus_idle: begin
          if (request) begin
            bus_state <= mmd_pkg::bus_fetch;
          end
        end
        mmd_pkg::bus_fetch:  bus_state <= mmd_pkg::bus_answer;
        mmd_pkg::bus_answer: bus_state <= mmd_pkg::bus_idle;
        default:             bus_state <= mmd_pkg::bus_idle;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= bus_state != mmd_pkg::bus_fetch;
    end
  end

  // Value of the addressed register, also the base for byte merges
  always_comb begin
    current_value = 16'h0000;
    if (hits(address, `IDX_ACCESS_CONTROL)) begin
      current_value = {access_control.port_function_select, 9'h000,
                       access_control.selected_space_id};
    end else if (port_access) begin
      if (!slot_valid) begin
        current_value = 16'h0000;
      end else if (data_function) begin
        current_value = memory_data;
      end else begin
        current_value = selected_address;
      end
    end else if (hits(address, `IDX_SPEED_CAPABILITY)) begin
      current_value = `SPEED_CAPABILITY_VALUE;
    end else if (hits(address, `IDX_LINE_CONTROL)) begin
      current_value = {9'h000, line_control.pair_swap_mode, 1'b0,
                       line_control.carrier_on_transmit,
                       line_control.heartbeat_test_enable,
                       line_control.polarity_reversal_enable,
                       line_control.jabber_detect_disable};
    end
  end

  // Read data are loaded on the same edge that waitrequest falls
  always_ff @(posedge clock) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (bus_state == mmd_pkg::bus_fetch) begin
      readdata <= {16'h0000, current_value};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      access_control <= '{mmd_pkg::port_address, 5'h00};
    end else if (commit && write && hits(address, `IDX_ACCESS_CONTROL)) begin
      // Bits 13:5 are dropped here so they always read back as zero
      access_control.port_function_select <=
        mmd_pkg::port_function_type'(merged[15:14]);
      access_control.selected_space_id <= merged[4:0];
    end
  end

  // One stored address per extended space
  for (genvar g = 0; g < 3; g++) begin : gen_space
    always_ff @(posedge clock) begin
      if (reset) begin
        space_address[g] <= 16'h0000;
      end else if (commit && port_access && slot == 2'(g)) begin
        if (!data_function && write) begin
          space_address[g] <= merged;
        end else if (data_function && step_address) begin
          space_address[g] <= space_address[g] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      line_control <= '{`PAIR_SWAP_RESET, 1'b0, 1'b0,
                        `POLARITY_REV_RESET, 1'b0};
    end else if (commit && write && hits(address, `IDX_LINE_CONTROL)) begin
      // The reserved pair swap code is stored as written
      line_control.pair_swap_mode           <= merged[6:5];
      line_control.carrier_on_transmit      <= merged[3];
      line_control.heartbeat_test_enable    <= merged[2];
      line_control.polarity_reversal_enable <= merged[1];
      line_control.jabber_detect_disable    <= merged[0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      line_control_out <= '{`PAIR_SWAP_RESET, 1'b0, 1'b0,
                            `POLARITY_REV_RESET, 1'b0};
    end else begin
      line_control_out <= line_control;
    end
  end

  // Line status arrives from the analog side, so it is synchronised
  always_ff @(posedge clock) begin
    if (reset) begin
      link_meta <= '0;
      link_sync <= '0;
    end else begin
      link_meta <= link_state;
      link_sync <= link_meta;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      line_action <= '0;
    end else begin
      if ((link_sync.speed == `SPEED_10 && !link_sync.full_duplex)
          || link_sync.speed == `SPEED_100) begin
        line_action.carrier_sense <= link_sync.receiving
          | (line_control.carrier_on_transmit
             & link_sync.transmitting);
      end else begin
        line_action.carrier_sense <= link_sync.receiving;
      end
      line_action.heartbeat_test_active <=
        line_control.heartbeat_test_enable
        & !link_sync.full_duplex;
      line_action.force_normal_polarity <=
        !line_control.polarity_reversal_enable
        & (link_sync.speed == `SPEED_10);
      line_action.jabber_detect_active <=
        !line_control.jabber_detect_disable
        & (link_sync.speed == `SPEED_10);
    end
  end

endmodule : mmd_control

`default_nettype wire

// ### dv/mmd_control_properties.sv
`timescale 1ns/100ps
`default_nettype none

module mmd_control_properties (
  input wire logic                      clock,
  input wire logic                      reset,
  input wire logic [7:0]                address,
  input wire logic                      read,
  input wire logic                      write,
  input wire logic [31:0]               readdata,
  input wire logic                      waitrequest,
  input wire mmd_pkg::link_state_type   link_state,
  input wire mmd_pkg::line_control_type line_control_out,
  input wire mmd_pkg::line_action_type  line_action
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  property p_answer;
    $rose(read || write) |=> waitrequest ##1 !waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer not two cycles after request");
  property p_one_cycle;
    !waitrequest |=> waitrequest;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("waitrequest low longer than one cycle");
  property p_upper_zero;
    !waitrequest |-> readdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read data not zero");
  property p_capability;
    read && !waitrequest && address == 8'h3c |-> readdata[15:0] == 16'h2000;
  endproperty
  a_capability: assert property (p_capability)
    else $error("capability status wrong");
  property p_line_read;
    read && !waitrequest && address == 8'h40 |-> readdata[15:0] ==
      {9'h0, line_control_out[5:4], 1'b0, line_control_out[3:0]};
  endproperty
  a_line_read: assert property (p_line_read)
    else $error("line control read differs from its copy");
  property p_access_reserved;
    read && !waitrequest && address == 8'h34 |-> readdata[13:5] == 9'h0;
  endproperty
  a_access_reserved: assert property (p_access_reserved)
    else $error("access control reserved bits set");
  // Four samples cover the two-flop synchroniser plus the action flop
  property p_jabber;
    line_control_out.jabber_detect_disable [*4] |->
      !line_action.jabber_detect_active;
  endproperty
  a_jabber: assert property (p_jabber)
    else $error("jabber detection active while disabled");
  property p_full_duplex;
    link_state.full_duplex [*4] |-> !line_action.heartbeat_test_active;
  endproperty
  a_full_duplex: assert property (p_full_duplex)
    else $error("heartbeat test active in full duplex");
  property p_polarity;
    line_control_out.polarity_reversal_enable [*4] |->
      !line_action.force_normal_polarity;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("normal polarity forced while reversal enabled");
endmodule : mmd_control_properties

bind mmd_control mmd_control_properties u_mmd_control_properties (
  .clock(clock), .reset(reset), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .link_state(link_state), .line_control_out(line_control_out),
  .line_action(line_action));

`default_nettype wire

// ### dv/mmd_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module mmd_control_tb_top;
  localparam logic [7:0] AC = 8'h34;
  localparam logic [7:0] PORT = 8'h38;
  localparam logic [7:0] CAP = 8'h3c;
  localparam logic [7:0] LC = 8'h40;
  logic                      clock;
  logic                      reset;
  logic [7:0]                address;
  logic                      read;
  logic                      write;
  logic [31:0]               writedata;
  logic [3:0]                byteenable;
  logic [31:0]               readdata;
  logic                      waitrequest;
  mmd_pkg::link_state_type   link_state;
  mmd_pkg::line_control_type line_control_out;
  mmd_pkg::line_action_type  line_action;
  int                        fail_count;
  int                        n_tests;

  mmd_control u_mmd_control (
    .clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .link_state(link_state), .line_control_out(line_control_out),
    .line_action(line_action));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // Request holds until waitrequest is seen low; the extra edge keeps
  // two back-to-back calls from driving read twice in one time step
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= {16'h0, d};
    read <= !wr;
    write <= wr;
    @(posedge clock);
    // Only the watchdog ends a wait that never sees waitrequest low
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
      n++;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    check(n, 32'd2, "answer latency");
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string what);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, q);
    check(q, {16'h0, e}, what);
  endtask : rd

  task automatic aim(input logic [1:0] fn, input logic [4:0] sp,
                     input logic [15:0] at);
    wr(AC, {11'h0, sp});
    wr(PORT, at);
    wr(AC, {fn, 9'h0, sp});
  endtask : aim

  task automatic t_reset;
    rd(AC, 16'h0, "control reset");
    rd(PORT, 16'h0, "port reset");
    rd(CAP, 16'h2000, "capability");
    rd(LC, 16'h0062, "line reset");
    check({26'h0, line_control_out}, 32'h32, "line out");
    wr(CAP, 16'hffff);
    rd(CAP, 16'h2000, "capability write");
    wr(LC, 16'hffff);
    rd(LC, 16'h006f, "line reserved");
    rd(8'h44, 16'h0, "unmapped");
    $display("reset test done");
  endtask : t_reset

  task automatic t_address;
    logic [4:0] sp [3] = '{5'h01, 5'h03, 5'h07};
    for (int i = 0; i < 3; i++) aim(2'b00, sp[i], {11'h1, sp[i]});
    for (int i = 0; i < 3; i++) begin
      wr(AC, {11'h0, sp[i]});
      rd(PORT, {11'h1, sp[i]}, "space address");
    end
    wr(AC, 16'h0002);
    rd(PORT, 16'h0, "bad space");
    wr(AC, 16'h3fe3);
    rd(AC, 16'h0003, "control reserved");
    wr(AC, 16'h8007);
    rd(AC, 16'h8007, "control fields");
    // Single byte lanes merge with the value already held
    byteenable <= 4'h1;
    wr(AC, 16'h4003);
    rd(AC, 16'h8003, "low lane only");
    byteenable <= 4'h2;
    wr(AC, 16'h4001);
    byteenable <= 4'h3;
    rd(AC, 16'h4003, "high lane only");
    $display("address test done");
  endtask : t_address

  task automatic t_data;
    aim(2'b01, 5'h03, 16'h0004);
    wr(PORT, 16'ha1a1);
    rd(PORT, 16'ha1a1, "hold data");
    wr(AC, 16'h0003);
    rd(PORT, 16'h0004, "hold address");
    aim(2'b01, 5'h07, 16'h0004);
    wr(PORT, 16'h7777);
    aim(2'b10, 5'h03, 16'h0004);
    rd(PORT, 16'ha1a1, "space apart");
    wr(PORT, 16'hb2b2);
    wr(AC, 16'h0003);
    rd(PORT, 16'h0006, "inc all");
    aim(2'b11, 5'h03, 16'h0004);
    rd(PORT, 16'ha1a1, "inc write rd");
    rd(PORT, 16'ha1a1, "inc write rd");
    wr(PORT, 16'hc3c3);
    rd(PORT, 16'hb2b2, "inc write wr");
    wr(AC, 16'h0003);
    rd(PORT, 16'h0005, "inc write addr");
    aim(2'b01, 5'h07, 16'h0004);
    rd(PORT, 16'h7777, "space seven");
    $display("data test done");
  endtask : t_data

  task automatic t_line;
    logic [15:0] lcs [6] = '{16'h6c, 16'h67, 16'h68, 16'h60, 16'h60, 16'h68};
    logic [4:0]  lss [6] = '{5'h02, 5'h06, 5'h0a, 5'h09, 5'h0a, 5'h16};
    logic        cs  [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [3:0]  acts [2] = '{4'hf, 4'h0};
    for (int m = 0; m < 4; m++) begin
      wr(LC, {9'h0, m[1:0], 5'h0});
      rd(LC, {9'h0, m[1:0], 5'h0}, "pair swap");
      check({26'h0, line_control_out},
            {26'h0, m[1:0], 4'h0}, "swap out");
    end
    for (int i = 0; i < 6; i++) begin
      wr(LC, lcs[i]);
      link_state <= mmd_pkg::link_state_type'(lss[i]);
      repeat (5) @(posedge clock);
      check({31'h0, line_action.carrier_sense},
            {31'h0, cs[i]}, "carrier");
      if (i < 2) begin
        check({28'h0, line_action},
              {28'h0, acts[i]}, "action");
      end
    end
    $display("line test done");
  endtask : t_line

  initial begin
    fail_count = 0;
    n_tests = 0;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h0;
    writedata = 32'h0;
    byteenable = 4'h3;
    link_state = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset;
    t_address;
    t_data;
    t_line;
    wrap_up;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    wrap_up;
  end
endmodule : mmd_control_tb_top

`default_nettype wire
